// File: serial_segment_map.vh
`ifndef SERIAL_SEGMENT_MAP_VH
`define SERIAL_SEGMENT_MAP_VH
// ****************************************
// Register indices
// ****************************************
`define REG_RX_BYTE_COUNT    8'h70
`define REG_RECEIVE_SEQ      8'h71
`define REG_TRANSMIT_SEQ_ACK 8'h72
`define REG_LINK_STATUS      8'h73
`define REG_DIAGNOSTIC       8'h74
`define REG_RECEIVE_PAYLOAD  8'h75
`define REG_RECEIVE_RELEASE  8'h76
`define REG_TX_BYTE_COUNT    8'h77
`define REG_TRANSMIT_SEQ     8'h78
`define REG_RECEIVE_SEQ_ACK  8'h79
`define REG_STATUS_CLEAR     8'h7A
`define REG_FLUSH_CONTROL    8'h7B
`define REG_HEADER_FORMAT    8'h80
`define REG_DIAG_BLOCK       8'h87
// ****************************************
// Field positions
// ****************************************
`define FLUSH_TX_BIT         0
`define FLUSH_RX_BIT         1
`define DIAG_PARAM_BIT       3
`define DIAG_HW_BIT          4
`define DIAG_HANDSHAKE_BIT   5
`define DIAG_FRAME_BIT       6
`define DIAG_OVERFLOW_BIT    7
// ****************************************
// Reset values and sizes
// ****************************************
`define SEQ_RESET            2'h0
`define LINK_OK              1'h1
`define BYTES_FULL_HEADER    3'h7
`define BYTES_DIAG_HEADER    3'h6
`define DIAG_RESERVED_MASK   8'hF8
`endif

// File: segment_sequencer.v
`timescale 1ns/100ps
`default_nettype none
`include "serial_segment_map.vh"
// ****************************************
// Two-bit wrapping sequence counter
// ****************************************
module segment_sequencer (
  // Clock and reset
  input  wire       i_clock,
  input  wire       i_sys_rst,
  // Control
  input  wire       i_step,
  // Value
  output reg  [1:0] o_value
);
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_value <= `SEQ_RESET;
    end else if (i_step) begin
      // Two bits wrap from 3 to 0 without a compare
      o_value <= o_value + 2'h1;
    end
  end
endmodule
`default_nettype wire

// File: sticky_flag.v
`timescale 1ns/100ps
`default_nettype none
`include "serial_segment_map.vh"
// ****************************************
// Sticky flag, set beats clear
// ****************************************
module sticky_flag (
  // Clock and reset
  input  wire i_clock,
  input  wire i_sys_rst,
  // Events
  input  wire i_set,
  input  wire i_clear,
  // Flag
  output reg  o_flag
);
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_flag <= 1'h0;
    end else if (i_set) begin
      o_flag <= 1'h1;
    end else if (i_clear) begin
      o_flag <= 1'h0;
    end
  end
endmodule
`default_nettype wire

// File: serial_segment_handshake.v
`timescale 1ns/100ps
`default_nettype none
`include "serial_segment_map.vh"
module serial_segment_handshake #(
  parameter SEG_BYTES = 8
) (
  // Clock and reset
  input  wire                   i_clock,
  input  wire                   i_sys_rst,
  // Attribute access from the gateway
  input  wire [7:0]             i_reg_addr,
  input  wire                   i_reg_write,
  input  wire                   i_reg_read,
  input  wire [63:0]            i_reg_wdata,
  output reg  [63:0]            o_reg_rdata,
  output wire                   o_reg_ack,
  output wire                   o_reg_error,
  // Receive segment from the serial side
  input  wire                   i_rx_seg_valid,
  input  wire [63:0]            i_rx_seg_data,
  input  wire [2:0]             i_rx_seg_count,
  output wire                   o_rx_seg_ready,
  // Transmit segment to the serial side
  output reg                    o_tx_seg_valid,
  output reg  [63:0]            o_tx_seg_data,
  output reg  [2:0]             o_tx_seg_count,
  input  wire                   i_tx_seg_ready,
  // Buffer flush strobes
  output reg                    o_tx_flush,
  output reg                    o_rx_flush,
  // Error events from the serial side
  input  wire                   i_link_fault,
  input  wire                   i_param_error,
  input  wire                   i_hw_failure,
  input  wire                   i_handshake_error,
  input  wire                   i_frame_error,
  input  wire                   i_rx_overflow,
  // Diagnostic message out
  output wire                   o_diag_message
);
  // ****************************************
  // Decoding
  // ****************************************
  function is_reg;
    input [7:0] addr;
    input [7:0] idx;
    begin
      is_reg = (addr == idx);
    end
  endfunction

  wire wr = i_reg_write;
  wire rd = i_reg_read;
  wire mapped = is_reg(i_reg_addr, `REG_RX_BYTE_COUNT)
              | ((i_reg_addr >= `REG_RECEIVE_SEQ)
                 & (i_reg_addr <= `REG_FLUSH_CONTROL))
              | is_reg(i_reg_addr, `REG_HEADER_FORMAT)
              | is_reg(i_reg_addr, `REG_DIAG_BLOCK);
  assign o_reg_ack   = (wr | rd) & mapped;
  assign o_reg_error = (wr | rd) & ~mapped;

  // ****************************************
  // Gateway side registers
  // ****************************************
  reg        status_clear_request;
  reg [2:0]  transmit_byte_count;
  reg [1:0]  transmit_sequence;
  reg [1:0]  transmit_sequence_ack;
  reg [1:0]  receive_sequence_ack;
  reg [7:0]  buffer_flush_control;
  reg        header_format;
  reg        diag_block;
  reg [63:0] tx_payload;

  wire req_write = wr & is_reg(i_reg_addr, `REG_STATUS_CLEAR);
  wire req_fall  = req_write & status_clear_request & ~i_reg_wdata[0];
  wire req_rise  = req_write & ~status_clear_request & i_reg_wdata[0];
  // Changes only count while the request is held at 1
  wire seg_accept = status_clear_request;
  wire new_tx_seq = wr & is_reg(i_reg_addr, `REG_TRANSMIT_SEQ) & seg_accept
                  & (i_reg_wdata[1:0] != transmit_sequence);
  wire max_bytes_ok = header_format ?
                      (i_reg_wdata[2:0] <= `BYTES_DIAG_HEADER) : 1'h1;

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_clear_request  <= 1'h0;
      transmit_byte_count   <= 3'h0;
      transmit_sequence     <= `SEQ_RESET;
      transmit_sequence_ack <= `SEQ_RESET;
      receive_sequence_ack  <= `SEQ_RESET;
      buffer_flush_control  <= 8'h00;
      header_format         <= 1'h0;
      diag_block            <= 1'h0;
      tx_payload            <= 64'h0;
      o_tx_seg_valid        <= 1'h0;
      o_tx_seg_data         <= 64'h0;
      o_tx_seg_count        <= 3'h0;
      o_tx_flush            <= 1'h0;
      o_rx_flush            <= 1'h0;
    end else begin
      o_tx_flush <= 1'h0;
      o_rx_flush <= 1'h0;
      if (o_tx_seg_valid & i_tx_seg_ready) begin
        o_tx_seg_valid <= 1'h0;
      end
      if (req_write) begin
        status_clear_request <= i_reg_wdata[0];
      end
      if (wr & is_reg(i_reg_addr, `REG_HEADER_FORMAT)) begin
        header_format <= i_reg_wdata[0];
      end
      if (wr & is_reg(i_reg_addr, `REG_DIAG_BLOCK)) begin
        diag_block <= i_reg_wdata[0];
      end
      if (wr & is_reg(i_reg_addr, `REG_RECEIVE_PAYLOAD - 8'h01)) begin
        tx_payload <= i_reg_wdata;
      end
      if (wr & is_reg(i_reg_addr, `REG_TX_BYTE_COUNT) & seg_accept
          & max_bytes_ok) begin
        transmit_byte_count <= i_reg_wdata[2:0];
      end
      if (wr & is_reg(i_reg_addr, `REG_RECEIVE_SEQ_ACK) & seg_accept) begin
        receive_sequence_ack <= i_reg_wdata[1:0];
      end
      // New sequence hands the segment over; a write while the link is busy is dropped
      if (new_tx_seq & ~o_tx_seg_valid) begin
        transmit_sequence <= i_reg_wdata[1:0];
        o_tx_seg_valid    <= 1'h1;
        o_tx_seg_data     <= tx_payload;
        o_tx_seg_count    <= transmit_byte_count;
      end
      if (o_tx_seg_valid & i_tx_seg_ready) begin
        transmit_sequence_ack <= transmit_sequence;
      end
      if (wr & is_reg(i_reg_addr, `REG_FLUSH_CONTROL)) begin
        buffer_flush_control <= i_reg_wdata[7:0];
        // Refused while the request is 1 or rising
        if (~status_clear_request & ~req_rise) begin
          o_tx_flush <= i_reg_wdata[`FLUSH_TX_BIT];
          o_rx_flush <= i_reg_wdata[`FLUSH_RX_BIT];
        end
      end
    end
  end

  // ****************************************
  // Receive segment holding
  // ****************************************
  reg        rx_full;
  reg [63:0] rx_data;
  reg [2:0]  rx_count;
  wire       rx_release = rd & is_reg(i_reg_addr, `REG_RECEIVE_RELEASE);
  wire [2:0] rx_limit = header_format ? `BYTES_DIAG_HEADER
                                      : `BYTES_FULL_HEADER;
  // One segment deep: the serial side waits until released or flushed
  assign o_rx_seg_ready = ~rx_full | rx_release;
  wire rx_take = i_rx_seg_valid & o_rx_seg_ready;

  wire [1:0] receive_sequence_w;
  segment_sequencer rx_seq_counter (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_step    (rx_take),
    .o_value   (receive_sequence_w)
  );

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_full  <= 1'h0;
      rx_data  <= 64'h0;
      rx_count <= 3'h0;
    end else begin
      if (rx_take) begin
        rx_full  <= 1'h1;
        rx_data  <= i_rx_seg_data;
        rx_count <= (i_rx_seg_count > rx_limit) ? rx_limit
                                                : i_rx_seg_count;
      end else if (rx_release | o_rx_flush) begin
        rx_full <= 1'h0;
      end
    end
  end

  // ****************************************
  // Link status and diagnostics
  // ****************************************
  wire [7:0] diag_events;
  assign diag_events[2:0] = 3'h0;
  assign diag_events[`DIAG_PARAM_BIT]     = i_param_error;
  assign diag_events[`DIAG_HW_BIT]        = i_hw_failure;
  assign diag_events[`DIAG_HANDSHAKE_BIT] = i_handshake_error;
  assign diag_events[`DIAG_FRAME_BIT]     = i_frame_error;
  assign diag_events[`DIAG_OVERFLOW_BIT]  = i_rx_overflow;

  wire [7:0] diag_flags;
  // Reserved positions never latch, whatever the event inputs do
  localparam [7:0] DIAG_MASK = `DIAG_RESERVED_MASK;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : diag_bits
      sticky_flag flag (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_set     (diag_events[g] & DIAG_MASK[g]),
        .i_clear   (req_fall),
        .o_flag    (diag_flags[g])
      );
    end
  endgenerate

  // Disturbed when any error or fault is seen; cleared on request fall
  wire link_down;
  sticky_flag link_flag (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_set     (i_link_fault | (|diag_events)),
    .i_clear   (req_fall),
    .o_flag    (link_down)
  );
  wire link_status = ~link_down;
  assign o_diag_message = link_down & ~diag_block;

  // ****************************************
  // Read data
  // ****************************************
  wire [7:0] diag_visible = header_format ? diag_flags : 8'h00;

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 64'h0;
    end else if (rd) begin
      case (i_reg_addr)
        `REG_RX_BYTE_COUNT:    o_reg_rdata <= {61'h0, rx_count};
        `REG_RECEIVE_SEQ:      o_reg_rdata <= {62'h0, receive_sequence_w};
        `REG_TRANSMIT_SEQ_ACK: o_reg_rdata <= {62'h0, transmit_sequence_ack};
        `REG_LINK_STATUS:      o_reg_rdata <= {63'h0, link_status};
        `REG_DIAGNOSTIC:       o_reg_rdata <= {56'h0, diag_visible};
        `REG_RECEIVE_PAYLOAD:  o_reg_rdata <= rx_data;
        `REG_RECEIVE_RELEASE:  o_reg_rdata <= rx_data;
        `REG_TX_BYTE_COUNT:    o_reg_rdata <= {61'h0, transmit_byte_count};
        `REG_TRANSMIT_SEQ:     o_reg_rdata <= {62'h0, transmit_sequence};
        `REG_RECEIVE_SEQ_ACK:  o_reg_rdata <= {62'h0, receive_sequence_ack};
        `REG_STATUS_CLEAR:     o_reg_rdata <= {63'h0, status_clear_request};
        `REG_FLUSH_CONTROL:    o_reg_rdata <= {56'h0, buffer_flush_control};
        `REG_HEADER_FORMAT:    o_reg_rdata <= {63'h0, header_format};
        `REG_DIAG_BLOCK:       o_reg_rdata <= {63'h0, diag_block};
        default:               o_reg_rdata <= 64'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: segment_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module segment_chk (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_sys_rst,
  // Watched ports
  input wire logic [7:0]  i_reg_addr,
  input wire logic        i_reg_write,
  input wire logic        i_reg_read,
  input wire logic [63:0] i_reg_wdata,
  input wire logic [63:0] o_reg_rdata,
  input wire logic        o_reg_ack,
  input wire logic        o_reg_error,
  input wire logic        i_rx_seg_valid,
  input wire logic        o_rx_seg_ready,
  input wire logic        o_tx_seg_valid,
  input wire logic        o_tx_flush,
  input wire logic        o_rx_flush
);
  // Request copy rebuilt from writes, reset value taken as 0
  logic req;
  wire  stb = i_reg_read | i_reg_write;
  wire  hit = (i_reg_addr >= 8'h70 && i_reg_addr <= 8'h7B) ||
              i_reg_addr == 8'h80 || i_reg_addr == 8'h87;
  wire  wfl = i_reg_write && i_reg_addr == 8'h7B && !req;
  wire  rel = i_reg_read && i_reg_addr == 8'h76;
  always @(posedge i_clock or posedge i_sys_rst)
    if (i_sys_rst)
      req <= 1'h0;
    else if (i_reg_write && i_reg_addr == 8'h7A)
      req <= i_reg_wdata[0];
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_map_ack: assert property (
    stb |-> o_reg_ack == hit && o_reg_error == !hit) else $error("bad ack");
  a_tx_flush: assert property (
    wfl && i_reg_wdata[0] |=> o_tx_flush) else $error("no tx flush");
  a_rx_flush: assert property (
    wfl && i_reg_wdata[1] |=> o_rx_flush) else $error("no rx flush");
  a_flush_cause: assert property (
    o_tx_flush || o_rx_flush |-> $past(wfl)) else $error("stray flush");
  a_rx_hold: assert property (
    i_rx_seg_valid && o_rx_seg_ready && !rel |=> rel || !o_rx_seg_ready)
    else $error("segment not held");
  a_rx_release: assert property (
    rel && !i_rx_seg_valid |=> o_rx_seg_ready) else $error("release ignored");
  a_count_range: assert property (
    i_reg_read && i_reg_addr == 8'h70 |=> o_reg_rdata[63:3] == 0)
    else $error("count too wide");
  a_diag_resv: assert property (
    i_reg_read && i_reg_addr == 8'h74 |=>
    o_reg_rdata[2:0] == 0 && o_reg_rdata[63:8] == 0) else $error("diag resv");
  a_seq_ignored: assert property (
    i_reg_write && i_reg_addr == 8'h78 && !req && !o_tx_seg_valid |=>
    !o_tx_seg_valid) else $error("sequence taken");
  cover property (o_tx_flush && o_rx_flush);
  cover property (o_tx_seg_valid);
  cover property (i_rx_seg_valid && o_rx_seg_ready);
endmodule
bind serial_segment_handshake segment_chk segment_chk_i (
  .i_clock, .i_sys_rst, .i_reg_addr, .i_reg_write, .i_reg_read,
  .i_reg_wdata, .o_reg_rdata, .o_reg_ack, .o_reg_error, .i_rx_seg_valid,
  .o_rx_seg_ready, .o_tx_seg_valid, .o_tx_flush, .o_rx_flush
);
`default_nettype wire

// File: gateway.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Gateway model
// ****************************************
module gateway (
  // Clock
  input  wire logic        i_clock,
  // Attribute access
  output var  logic [7:0]  o_addr,
  output var  logic        o_write,
  output var  logic        o_read,
  output var  logic [63:0] o_wdata,
  input  wire logic [63:0] i_rdata,
  input  wire logic        i_error
);
  logic [1:0]  tx_seq;
  logic [1:0]  rx_seq;
  logic [63:0] rx_data;
  logic [63:0] q;
  logic        e;
  initial begin
    tx_seq = 2'h0;
    o_addr = 8'h00;
    o_write = 1'h0;
    o_read = 1'h0;
    o_wdata = 64'h0;
  end
  // Idle bus shows the inverse, so stale values never look valid
  task access(input logic w, input logic [7:0] a, input logic [63:0] d);
    @(posedge i_clock);
    #1;
    o_addr = a;
    o_wdata = d;
    o_write = w;
    o_read = !w;
    #1;
    e = i_error;
    @(posedge i_clock);
    #1;
    q = i_rdata;
    o_write = 1'h0;
    o_read = 1'h0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task send(input logic [63:0] d, input logic [2:0] c);
    tx_seq = tx_seq + 2'h1;
    access(1'h1, 8'h7A, 64'h1);
    access(1'h1, 8'h74, d);
    access(1'h1, 8'h77, {61'h0, c});
    access(1'h1, 8'h78, {62'h0, tx_seq});
  endtask
  task take_rx;
    access(1'h0, 8'h76, 64'h0);
    rx_data = q;
    access(1'h0, 8'h71, 64'h0);
    rx_seq = q[1:0];
    access(1'h1, 8'h79, {62'h0, rx_seq});
  endtask
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module tb;
  logic        clock, rst, wr, rd, err, rxv, rxr, txv, txr, txf, rxf, dmsg;
  logic [7:0]  addr;
  logic [63:0] wdata, rdata, rxd, txd, d, x;
  logic [2:0]  rxc, txc, c;
  logic [5:0]  ev;
  logic [66:0] t;
  logic [66:0] txq[$];
  int          num_errors, samples_checked, k, n;
  int          nf[2];
  serial_segment_handshake serial_segment_handshake_i (
    .i_clock(clock), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_write(wr),
    .i_reg_read(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_ack(), .o_reg_error(err), .i_rx_seg_valid(rxv),
    .i_rx_seg_data(rxd), .i_rx_seg_count(rxc), .o_rx_seg_ready(rxr),
    .o_tx_seg_valid(txv), .o_tx_seg_data(txd), .o_tx_seg_count(txc),
    .i_tx_seg_ready(txr), .o_tx_flush(txf), .o_rx_flush(rxf),
    .i_link_fault(ev[0]), .i_param_error(ev[1]), .i_hw_failure(ev[2]),
    .i_handshake_error(ev[3]), .i_frame_error(ev[4]),
    .i_rx_overflow(ev[5]), .o_diag_message(dmsg));
  gateway gateway_i (.i_clock(clock), .o_addr(addr), .o_write(wr),
    .o_read(rd), .o_wdata(wdata), .i_rdata(rdata), .i_error(err));
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  // Sink stalls at random
  always begin
    @(posedge clock);
    #1 txr = 1'($urandom);
  end
  always @(posedge clock) begin
    if (txv === 1'h1 && txr === 1'h1)
      txq.push_back({txc, txd});
    if (txf === 1'h1)
      nf[0]++;
    if (rxf === 1'h1)
      nf[1]++;
  end
  task check(input string s, input logic [63:0] v, input logic [63:0] e);
    samples_checked++;
    if (v !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", s, e, v);
    end
  endtask
  task wrt(input logic [7:0] a, input logic [63:0] v);
    gateway_i.access(1'h1, a, v);
  endtask
  task rdr(input logic [7:0] a);
    gateway_i.access(1'h0, a, 64'h0);
  endtask
  task conclude;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(40 * 10000);
    num_errors++;
    conclude;
  end
  initial begin
    {rst, rxv, rxd, rxc, ev} = {1'h1, 74'h0};
    {num_errors, samples_checked, nf[0], nf[1]} = 128'h0;
    void'($urandom(98));
    repeat (8) @(posedge clock);
    #1 rst = 1'h0;
    rdr(8'h73);
    check("link", gateway_i.q, 64'h1);
    rdr(8'h7F);
    check("unmapped", gateway_i.e, 1'h1);
    for (k = 1; k <= 5; k++) begin
      d = {$urandom, $urandom};
      c = $urandom;
      gateway_i.send(d, c);
      for (n = 0; n < 40 && txq.size() == 0; n++)
        @(posedge clock);
      t = txq.size() ? txq.pop_front() : 'x;
      check("tx_data", t[63:0], d);
      check("tx_count", t[66:64], c);
      rdr(8'h72);
      check("tx_ack", gateway_i.q, k % 4);
    end
    // Request low: new sequence ignored, flushes honoured
    wrt(8'h7A, 64'h0);
    wrt(8'h78, 64'h2);
    repeat (4) @(posedge clock);
    check("tx_ignored", txq.size(), 0);
    wrt(8'h7B, 64'h1);
    wrt(8'h7B, 64'h2);
    wrt(8'h7A, 64'h1);
    wrt(8'h7B, 64'h3);
    repeat (2) @(posedge clock);
    check("tx_flush", nf[0], 1);
    check("rx_flush", nf[1], 1);
    for (k = 1; k <= 5; k++) begin
      check("rx_ready", rxr, 1'h1);
      {rxd, rxc, rxv} = {$urandom, $urandom, 3'($urandom), 1'h1};
      @(posedge clock);
      #1 {rxv, rxd} = {1'h0, ~rxd};
      rdr(8'h70);
      check("rx_count", gateway_i.q, rxc);
      gateway_i.take_rx;
      check("rx_data", gateway_i.rx_data, ~rxd);
      check("rx_seq", gateway_i.rx_seq, k % 4);
    end
    wrt(8'h80, 64'h1);
    for (k = 0; k < 7; k++) begin
      // Last pass: format 0 hides a real diag event, message blocked
      if (k == 6) begin
        wrt(8'h80, 64'h0);
        wrt(8'h87, 64'h1);
      end
      @(posedge clock);
      #1 ev[k % 6 + (k == 6)] = 1'h1;
      @(posedge clock);
      #1 ev = 6'h0;
      rdr(8'h73);
      check("link_down", gateway_i.q, 64'h0);
      check("diag_msg", dmsg, k != 6);
      rdr(8'h74);
      x = (k % 6) ? 64'h1 << (k + 2) : 64'h0;
      check("diag", gateway_i.q, x);
      wrt(8'h7A, 64'h0);
      rdr(8'h73);
      check("link_up", gateway_i.q, 64'h1);
      wrt(8'h7A, 64'h1);
    end
    conclude;
  end
endmodule
`default_nettype wire
